// >>> core/ims_sequencer.v
// Input multiplexer frame sequencer with AHB-Lite register slave
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ims_consts.vh"
// Overview
// The sequencer walks a frame of one to ten slots. Each slot routes one
// signal number to the converter and pulses fir_start as it begins.
// After the last slot one extra sample cycle follows with the frame sync
// held high; the chop polarity and the pair return side move at its start.
// Timing base
// The sample clock is a level seen on mclk. A rising edge is detected one
// mclk later, so every slot and sync boundary lags that edge by one or two
// mclk cycles. The sample clock must stay well below half the mclk rate.
// Slot length
// A slot lasts as many sample cycles as the filter length field says,
// with zero treated as one. Changing the field mid-slot takes effect at
// once; the slot ends as soon as the spent count reaches the new length.
// Slot count
// Zero slots behaves as one and counts above ten as ten. Lowering the
// count mid-frame ends the frame at the first slot at or past the new end,
// so the slot index can never run off the selection words.
// Alternate frames
// Software toggles the request bit; only its rising edge matters, so a
// pulse one bus write long is enough. The edge is latched as pending and
// consumed when the next frame starts. Edges that arrive before that start
// merge into a single alternate frame; an edge in the very cycle of the
// start is folded into the frame that begins then.
// Battery path
// The battery path closes only during an alternate frame, only in a slot
// whose alternate pick is the battery signal, and only while the enable
// bit is set and system power is present.
// Chop modes
// Positive holds the cross signal low, reverse holds it high. Plain toggle
// flips it every frame. The alternate-aware toggle skips the flip ahead of
// an alternate frame so that successive alternate frames see opposite
// polarities.
// Register map
// Control, normal picks low and high, alternate picks low and high and a
// read-only status word, one aligned word each. The high words carry slots
// eight and nine in their low byte. Unmapped reads return zero and
// unmapped writes are dropped.
// Status word
// Bits three to zero hold the slot index, five and four the sample cycles
// spent in it, six the cross signal, seven the sync cycle flag, eight the
// frame kind and nine a pending alternate request.
// Bus timing
// Zero wait states with an OKAY answer always. Writes land at the end of
// the data phase; read data is fetched at the address phase and stands
// through the data phase.
// Limits
// No wait states are ever inserted, so hready is only used to qualify the
// address phase. The transfer size is not checked: every access is taken
// as a whole word.
// Outputs
// Every output comes from a flop. The selection, result location, battery
// path and frame kind move one mclk after the slot state, so they settle
// just after each fir_start pulse. The result location equals the signal
// number, so battery results land at location eleven.
// Pair configuration
// Each of the four current pairs is differential when its control bit is
// set. A differential pair swaps the side tied to the analog supply return
// once per frame; single-ended pairs always show zero on that output.
// Reset
// The asynchronous reset loads a count of seven and the default picks,
// parks the sequencer on slot zero and clears every pulse. The first
// sample edge after reset ends slot zero.
module ims_sequencer (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        slow_sample_clock,
    input  wire        system_power_ok,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [3:0]  input_select,
    output reg  [3:0]  result_location,
    output reg         battery_path_on,
    output reg         fir_start,
    output reg         frame_sync_pulse,
    output reg         chop_cross,
    output reg  [3:0]  pair_differential,
    output reg  [3:0]  pair_return_to_neg,
    output reg         alternate_active
);
    // Sequencer states
    localparam ST_SLOT = 1'b0;
    localparam ST_SYNC = 1'b1;

    // Software controls
    reg  [13:0] ctrl;                 // Control fields
    reg  [39:0] normal_slot_selection;    // Ten 4-bit normal picks
    reg  [39:0] alternate_slot_selection; // Ten 4-bit alternate picks
    reg         pending_alt;          // Latched alternate request
    reg         req_prev;             // Request level one cycle ago

    // Sequencer state
    reg         state;                // Slot or sync cycle
    reg  [3:0]  slot;                 // Current slot index
    reg  [1:0]  cyc;                  // Sample cycles spent in slot
    reg         ck_prev;              // Sample clock last cycle
    reg         frame_alt;            // Current frame is alternate
    reg         chop_phase;           // Return side for chopped pairs

    // Bus pipeline
    reg         ph_valid;             // Data phase pending
    reg         ph_write;             // Pending is a write
    reg  [7:0]  ph_addr;              // Pending byte address

    wire [3:0] slot_count_field    = ctrl[`IMS_CTRL_COUNT_MSB:`IMS_CTRL_COUNT_LSB];
    wire [1:0] filter_length_field = ctrl[`IMS_CTRL_FIR_MSB:`IMS_CTRL_FIR_LSB];
    wire [1:0] chop_polarity_mode  = ctrl[`IMS_CTRL_CHOP_MSB:`IMS_CTRL_CHOP_LSB];
    wire       alternate_frame_request = ctrl[`IMS_CTRL_ALT_BIT];
    // Enable ignored without system power
    wire       battery_measure_enable = ctrl[`IMS_CTRL_BME_BIT] & system_power_ok;
    // Count of zero or above ten clamps to legal range
    wire [3:0] slots_used = (slot_count_field == 4'h0) ? 4'h1 :
                            (slot_count_field > `IMS_MAX_SLOTS) ? `IMS_MAX_SLOTS :
                            slot_count_field;
    // Filter length of zero still takes one sample cycle
    wire [1:0] cycles_used = (filter_length_field == 2'h0) ? 2'h1 : filter_length_field;
    wire       ck_rise = slow_sample_clock & ~ck_prev;
    wire       req_rise = alternate_frame_request & ~req_prev;
    // At-or-past compares guard against counts lowered mid-frame
    wire       last_slot = (slot >= slots_used - 4'h1);
    wire       slot_done = (cyc >= cycles_used - 2'h1);

    // Selection mux for the current slot
    reg  [3:0] next_select;
    always @* begin
        next_select = frame_alt ? alternate_slot_selection[slot*4 +: 4]
                                : normal_slot_selection[slot*4 +: 4];
    end

    // Chop polarity update at frame end
    reg next_cross;
    always @* begin
        case (chop_polarity_mode)
            `IMS_CHOP_POSITIVE: next_cross = 1'b0;
            `IMS_CHOP_REVERSE:  next_cross = 1'b1;
            // Hold before an alternate frame so alternate frames alternate
            `IMS_CHOP_TOGGLE_ALT: next_cross = pending_alt ? chop_cross : ~chop_cross;
            default:            next_cross = ~chop_cross;
        endcase
    end

    // Bus slave: zero wait states, always OKAY
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ph_valid  <= 1'b0;
            ph_write  <= 1'b0;
            ph_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                ph_valid <= hsel & htrans[1];
                ph_write <= hwrite;
                ph_addr  <= haddr[7:0];
            end
        end
    end

    // Register writes and read data
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl                     <= `IMS_CTRL_RESET;
            normal_slot_selection    <= `IMS_SEL_RESET;
            alternate_slot_selection <= `IMS_ALT_RESET;
            hrdata                   <= 32'h0000_0000;
        end else begin
            if (ph_valid && ph_write) begin
                // A one-cycle pulse of the request bit is caught below
                if (ph_addr == `IMS_ADDR_CTRL) begin
                    ctrl <= hwdata[13:0];
                end else if (ph_addr == `IMS_ADDR_SEL_LO) begin
                    normal_slot_selection[31:0] <= hwdata;
                end else if (ph_addr == `IMS_ADDR_SEL_HI) begin
                    normal_slot_selection[39:32] <= hwdata[7:0];
                end else if (ph_addr == `IMS_ADDR_ALT_LO) begin
                    alternate_slot_selection[31:0] <= hwdata;
                end else if (ph_addr == `IMS_ADDR_ALT_HI) begin
                    alternate_slot_selection[39:32] <= hwdata[7:0];
                end
            end
            // Read data presented for the next address phase's data phase
            if (hready && hsel && htrans[1] && !hwrite) begin
                if (haddr[7:0] == `IMS_ADDR_CTRL) begin
                    hrdata <= {18'h00000, ctrl};
                end else if (haddr[7:0] == `IMS_ADDR_SEL_LO) begin
                    hrdata <= normal_slot_selection[31:0];
                end else if (haddr[7:0] == `IMS_ADDR_SEL_HI) begin
                    hrdata <= {24'h000000, normal_slot_selection[39:32]};
                end else if (haddr[7:0] == `IMS_ADDR_ALT_LO) begin
                    hrdata <= alternate_slot_selection[31:0];
                end else if (haddr[7:0] == `IMS_ADDR_ALT_HI) begin
                    hrdata <= {24'h000000, alternate_slot_selection[39:32]};
                end else if (haddr[7:0] == `IMS_ADDR_STATUS) begin
                    hrdata <= {22'h00_0000, pending_alt, frame_alt, state, chop_cross,
                               cyc, slot};
                end else begin
                    // Unmapped reads return zero
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Frame sequencer, stepped on each sample clock rising edge
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_prev    <= 1'b0;
            pending_alt <= 1'b0;
            ck_prev     <= 1'b0;
            state       <= ST_SLOT;
            slot        <= 4'h0;
            cyc         <= 2'h0;
            frame_alt   <= 1'b0;
            chop_cross  <= 1'b0;
            chop_phase  <= 1'b0;
            fir_start   <= 1'b0;
            frame_sync_pulse <= 1'b0;
        end else begin
            req_prev <= alternate_frame_request;
            ck_prev  <= slow_sample_clock;
            fir_start <= 1'b0;
            // Frame start consumes the request; a same-cycle edge is
            // already folded into frame_alt, so keeping it would give two
            if (ck_rise && state == ST_SYNC) begin
                pending_alt <= 1'b0;
            end else if (req_rise) begin
                pending_alt <= 1'b1;
            end
            if (ck_rise) begin
                case (state)
                    ST_SLOT: begin
                        if (slot_done) begin
                            cyc <= 2'h0;
                            if (last_slot) begin
                                // Extra settle cycle, sync high, chop updates
                                state            <= ST_SYNC;
                                frame_sync_pulse <= 1'b1;
                                chop_cross       <= next_cross;
                                chop_phase       <= ~chop_phase;
                            end else begin
                                slot      <= slot + 4'h1;
                                fir_start <= 1'b1;
                            end
                        end else begin
                            cyc <= cyc + 2'h1;
                        end
                    end
                    default: begin
                        // New frame always begins at first slot
                        state            <= ST_SLOT;
                        slot             <= 4'h0;
                        cyc              <= 2'h0;
                        frame_sync_pulse <= 1'b0;
                        fir_start        <= 1'b1;
                        frame_alt        <= pending_alt | req_rise;
                    end
                endcase
            end
        end
    end

    // Mux outputs registered from slot state
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            input_select       <= `IMS_SIG_PHASE_A_CURRENT;
            result_location    <= 4'h0;
            battery_path_on    <= 1'b0;
            pair_differential  <= 4'h0;
            pair_return_to_neg <= 4'h0;
            alternate_active   <= 1'b0;
        end else begin
            input_select     <= next_select;
            // Result location equals signal number, battery lands at 0x0B
            result_location  <= next_select;
            battery_path_on  <= battery_measure_enable && frame_alt &&
                                (next_select == `IMS_SIG_BATTERY);
            pair_differential <= ctrl[`IMS_CTRL_DIFF_MSB:`IMS_CTRL_DIFF_LSB];
            pair_return_to_neg <= ctrl[`IMS_CTRL_DIFF_MSB:`IMS_CTRL_DIFF_LSB] &
                                  {4{chop_phase}};
            alternate_active <= frame_alt;
        end
    end
endmodule
`default_nettype wire

// >>> core/ims_consts.vh
// Constants for the input multiplexer frame sequencer
// Notes on behaviour
// - One to ten slots per frame from count
// - Frame starts slot zero, runs count slots
// - One input routed per slot
// - Normal frames use normal slot selections
// - Alternate frames use 4-bit alternate selections
// - Battery path only while battery enable set
// - Frame control advances slots, starts conversions
// - Frame control runs on slow sample clock
// - One-cycle alternate request still honoured
// - Request edge gives one alternate frame next
// - Each current pair differential or single-ended
// - Chopped differential return swaps each frame
// - Signal 0 phase A current, 1 voltage
// - Slot lasts one to three sample cycles
// - Extra sync cycle after last slot, chop update
// - Battery result stored at location 0x0B
// - Battery enable forced zero without system power
`ifndef IMS_CONSTS_VH
`define IMS_CONSTS_VH
// Register byte addresses
`define IMS_ADDR_CTRL     8'h00
`define IMS_ADDR_SEL_LO   8'h04
`define IMS_ADDR_SEL_HI   8'h08
`define IMS_ADDR_ALT_LO   8'h0c
`define IMS_ADDR_ALT_HI   8'h10
`define IMS_ADDR_STATUS   8'h14
// Control register fields
`define IMS_CTRL_COUNT_LSB 0
`define IMS_CTRL_COUNT_MSB 3
`define IMS_CTRL_FIR_LSB   4
`define IMS_CTRL_FIR_MSB   5
`define IMS_CTRL_CHOP_LSB  6
`define IMS_CTRL_CHOP_MSB  7
`define IMS_CTRL_ALT_BIT   8
`define IMS_CTRL_BME_BIT   9
`define IMS_CTRL_DIFF_LSB  10
`define IMS_CTRL_DIFF_MSB  13
// Reset values
`define IMS_CTRL_RESET     14'h0007
`define IMS_SEL_RESET      40'h9876543210
`define IMS_ALT_RESET      40'h98765b3a1a
// Chop modes
`define IMS_CHOP_TOGGLE_ALT 2'h0
`define IMS_CHOP_POSITIVE   2'h1
`define IMS_CHOP_REVERSE    2'h2
`define IMS_CHOP_TOGGLE     2'h3
// Signal numbers and memory locations
`define IMS_SIG_PHASE_A_CURRENT 4'h0
`define IMS_SIG_PHASE_A_VOLTAGE 4'h1
`define IMS_SIG_BATTERY         4'hb
`define IMS_BATTERY_LOCATION    4'hb
`define IMS_MAX_SLOTS           4'ha
`endif

// >>> sim/ims_sequencer_sva.sv
// Port checker for the input multiplexer frame sequencer
`timescale 1ns/10ps
`default_nettype none
module ims_sequencer_sva (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       system_power_ok,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [3:0] input_select,
    input wire logic [3:0] result_location,
    input wire logic       battery_path_on,
    input wire logic       fir_start,
    input wire logic       frame_sync_pulse,
    input wire logic       chop_cross,
    input wire logic       alternate_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Zero-wait slave, always OKAY
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer late or not okay");
    property p_fir_pulse; fir_start |=> !fir_start; endproperty
    a_fir_pulse: assert property (p_fir_pulse) else $error("slot start too long");
    property p_frame_fir; $fell(frame_sync_pulse) |-> ##[0:2] fir_start; endproperty
    a_frame_fir: assert property (p_frame_fir) else $error("frame without slot start");
    // Sync spans one whole sample cycle, bench sample period is 16 mclk
    property p_sync_len;
        $rose(frame_sync_pulse) |-> frame_sync_pulse[*8] ##[1:24] !frame_sync_pulse;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync length wrong");
    property p_cross; $changed(chop_cross) |-> ##[0:2] frame_sync_pulse; endproperty
    a_cross: assert property (p_cross) else $error("chop moved outside sync");
    // Frame kind only changes as a frame begins
    property p_alt;
        $changed(alternate_active) |-> $past(frame_sync_pulse) || $past(frame_sync_pulse, 2);
    endproperty
    a_alt: assert property (p_alt) else $error("frame kind changed mid frame");
    property p_bat; battery_path_on |-> alternate_active && input_select == 4'hb; endproperty
    a_bat: assert property (p_bat) else $error("battery path outside its slot");
    property p_pwr; !system_power_ok [*3] |-> !battery_path_on; endproperty
    a_pwr: assert property (p_pwr) else $error("battery path without power");
    property p_loc; battery_path_on |-> result_location == 4'hb; endproperty
    a_loc: assert property (p_loc) else $error("battery result misplaced");
    c_alt: cover property ($rose(alternate_active));
    c_bat: cover property ($rose(battery_path_on));
    c_sync: cover property ($rose(frame_sync_pulse));
endmodule
`default_nettype wire

// >>> sim/ims_afe_model.sv
// Converter, filter and engine stand-in: sample clock and slot recorder
`timescale 1ns/10ps
`default_nettype none
module ims_afe_model #(
    parameter int HALF = 8 // Shortened sample half period in mclk
) (
    input wire logic       mclk,
    input wire logic [3:0] input_select,
    input wire logic [3:0] result_location,
    input wire logic       battery_path_on,
    input wire logic       fir_start,
    output var logic       slow_sample_clock
);
    logic [3:0] sel_q[$]; // Input seen per slot
    logic [3:0] loc_q[$]; // Result location per slot
    logic       bat_q[$]; // Battery path per slot
    int         gap_q[$]; // Mclk cycles since previous slot start
    int         gap = 0;
    int         tick = 0;
    logic [2:0] fs_d = 3'h0;
    initial slow_sample_clock = 1'b0;
    // Free-running sample clock, never tied to frames
    always @(posedge mclk) begin
        tick = (tick + 1) % HALF;
        if (tick == 0) slow_sample_clock <= !slow_sample_clock;
        fs_d <= {fs_d[1:0], fir_start};
        gap = gap + 1;
        if (fir_start) begin
            gap_q.push_back(gap);
            gap = 0;
        end
        // Sample a settled slot, well clear of its start
        if (fs_d[2]) begin
            sel_q.push_back(input_select);
            loc_q.push_back(result_location);
            bat_q.push_back(battery_path_on);
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the frame sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ims_consts.vh"
module tb;
    logic        mclk = 1'b0, resetn = 1'b0, system_power_ok = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, battery_path_on, fir_start, frame_sync_pulse;
    wire         chop_cross, alternate_active, slow_sample_clock;
    wire  [3:0]  input_select, result_location, pair_differential, pair_return_to_neg;
    int          compares = 0, miscompares = 0;
    ims_sequencer dut_u (.mclk(mclk), .resetn(resetn), .slow_sample_clock(slow_sample_clock),
        .system_power_ok(system_power_ok), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .input_select(input_select),
        .result_location(result_location), .battery_path_on(battery_path_on),
        .fir_start(fir_start), .frame_sync_pulse(frame_sync_pulse), .chop_cross(chop_cross),
        .pair_differential(pair_differential), .pair_return_to_neg(pair_return_to_neg),
        .alternate_active(alternate_active));
    ims_afe_model #(.HALF(8)) afe_u (.mclk(mclk), .input_select(input_select),
        .result_location(result_location), .battery_path_on(battery_path_on),
        .fir_start(fir_start), .slow_sample_clock(slow_sample_clock));
    initial forever #2 mclk = !mclk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer; called just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        chk("register", x, exp);
    endtask
    task automatic start();
        @(negedge frame_sync_pulse);
        @(posedge mclk);
    endtask
    // Record one whole frame and judge each slot
    task automatic frame(input int n, input int fir, input logic [39:0] sel, input logic alt,
                         input logic bat);
        @(negedge frame_sync_pulse);
        afe_u.sel_q.delete();
        afe_u.loc_q.delete();
        afe_u.bat_q.delete();
        afe_u.gap_q.delete();
        @(posedge frame_sync_pulse);
        chk("alternate", alternate_active, alt);
        chk("slots", afe_u.sel_q.size(), n);
        for (int i = 0; i < afe_u.sel_q.size(); i++) begin
            chk("select", afe_u.sel_q[i], sel[4*i+:4]);
            chk("location", afe_u.loc_q[i], sel[4*i+:4]);
            chk("battery", afe_u.bat_q[i], bat && sel[4*i+:4] == 4'hb);
            if (i > 0) chk("slot length", afe_u.gap_q[i], fir * 16);
        end
    endtask
    task automatic t_regs();
        rd_chk(`IMS_ADDR_CTRL, 32'h7);
        rd_chk(`IMS_ADDR_SEL_LO, 32'h76543210);
        rd_chk(`IMS_ADDR_ALT_HI, 32'h98);
        rd_chk(8'h18, 32'h0);
    endtask
    task automatic t_normal();
        logic [3:0] r;
        logic       c;
        wr(`IMS_ADDR_CTRL, 32'h1417);
        frame(7, 1, `IMS_SEL_RESET, 1'b0, 1'b0);
        chk("pairs", pair_differential, 4'h5);
        repeat (2) @(posedge mclk);
        r = pair_return_to_neg;
        c = chop_cross;
        chk("return side", r & 4'ha, 4'h0);
        @(posedge frame_sync_pulse);
        repeat (2) @(posedge mclk);
        chk("return side", pair_return_to_neg, r ^ 4'h5);
        chk("chop", chop_cross, !c);
        wr(`IMS_ADDR_SEL_HI, 32'h21);
        wr(`IMS_ADDR_CTRL, 32'h3a);
        frame(10, 3, {8'h21, 32'h76543210}, 1'b0, 1'b0);
    endtask
    // Short request pulses, two merged into one frame
    task automatic t_alt(input logic pwr, input logic bat);
        system_power_ok <= pwr;
        wr(`IMS_ADDR_CTRL, 32'h223);
        start();
        wr(`IMS_ADDR_CTRL, 32'h323);
        wr(`IMS_ADDR_CTRL, 32'h223);
        wr(`IMS_ADDR_CTRL, 32'h323);
        wr(`IMS_ADDR_CTRL, 32'h223);
        frame(3, 2, `IMS_ALT_RESET, 1'b1, bat);
        frame(3, 2, `IMS_SEL_RESET, 1'b0, 1'b0);
        system_power_ok <= 1'b1;
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_normal();
        t_alt(1'b1, 1'b1);
        t_alt(1'b0, 1'b0);
        results();
    end
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule
bind ims_sequencer ims_sequencer_sva chk_u (.mclk(mclk), .resetn(resetn),
    .system_power_ok(system_power_ok), .hreadyout(hreadyout), .hresp(hresp),
    .input_select(input_select), .result_location(result_location),
    .battery_path_on(battery_path_on), .fir_start(fir_start),
    .frame_sync_pulse(frame_sync_pulse), .chop_cross(chop_cross),
    .alternate_active(alternate_active));
`default_nettype wire
